// file: rtl/adc_ctrl_consts.vh
/*
 Register offsets, field positions, reset values and timing counts for the converter control block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
`define OFS_RESULT_LOW 4'h0
`define OFS_RESULT_HIGH 4'h4
`define OFS_CONTROL_0 4'h8
`define OFS_CONTROL_1 4'hc
`define OFS_PORT_SEL_0 5'h10
`define OFS_PORT_SEL_1 5'h14
`define OFS_IRQ_STATUS 5'h18
`define OFS_IRQ_MASK 5'h1c
`define CTL0_RESET 8'h60
`define CTL1_RESET 8'h00
`define CTL0_START 7
`define CTL0_BUSY 6
`define CTL0_POWER_DOWN 5
`define CTL1_BANDGAP 6
`define CTL1_ALIGN 5
`define REF_EXTERNAL 2'h1
`define CLK_SEL_SUB 3'h7
`define SUB_CLK_DIV 12'hc34
`define CONV_CLOCKS 5'h10
`define SRC_BANDGAP 4'ha
`define SRC_DEMOD 4'h8
`define SRC_OVERCURRENT 4'h9
`endif

// file: rtl/conv_clock_gen.v
/*
 Converter clock enable generator: one-cycle pulses at aclk divided by 1..64, or a slow subsystem rate.
 Assumes a single aclk domain; the subsystem rate is derived from aclk by a long divider.
*/
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module conv_clock_gen #(
   parameter [11:0] SUB_DIV = `SUB_CLK_DIV
)(
   input wire aclk,
   input wire aresetn,
   input wire [2:0] clk_sel,
   output reg tick
);
   reg [11:0] cnt_q;
   reg [11:0] limit;
   always @*
   begin
      if (clk_sel == `CLK_SEL_SUB)
         limit = SUB_DIV - 12'h001;
      else
         limit = (12'h001 << clk_sel) - 12'h001;
   end
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= 12'h000;
         tick <= 1'b0;
      end
      else if (cnt_q >= limit)
      begin
         cnt_q <= 12'h000;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 12'h001;
         tick <= 1'b0;
      end
   end
endmodule

// file: rtl/pin_function_mux.v
/*
 Per-pin function steering for eight shared port pins.
 Assumes the pad logic honours the enables given here.
*/
`timescale 1ns/1ps
module pin_function_mux #(
   parameter PINS = 8
)(
   input wire [PINS-1:0] analog_sel,
   input wire [PINS-1:0] pull_up_cfg,
   input wire [PINS-1:0] digital_oe_req,
   output wire [PINS-1:0] analog_connect,
   output wire [PINS-1:0] digital_enable,
   output wire [PINS-1:0] digital_oe,
   output wire [PINS-1:0] pull_up_enable
);
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1)
      begin : g_pin
         assign analog_connect[i] = analog_sel[i];
         assign digital_enable[i] = ~analog_sel[i];
         assign digital_oe[i] = digital_oe_req[i] & ~analog_sel[i];
         assign pull_up_enable[i] = pull_up_cfg[i] & ~analog_sel[i];
      end
   endgenerate
endmodule

// file: rtl/adc_conversion_control.v
/*
 Converter control: AXI4-Lite registers, start/reset handshake, busy flag, channel and reference
 selection, result formatting, pin steering and interrupt.
 Assumes the analog core samples at each converter clock tick and offers its 12-bit value at the end.
*/
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module adc_conversion_control #(
   parameter [11:0] SUB_DIV = `SUB_CLK_DIV,
   parameter PINS = 8
)(
   input wire aclk,
   input wire aresetn,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [11:0] core_result,
   output reg core_reset,
   output reg core_power_on,
   output reg core_sample,
   output reg [3:0] source_select,
   output reg [1:0] reference_select,
   output reg reference_pin_claim,
   output reg bandgap_on,
   input wire [PINS-1:0] pull_up_cfg,
   input wire [PINS-1:0] digital_oe_req,
   output wire [PINS-1:0] analog_connect,
   output wire [PINS-1:0] digital_enable,
   output wire [PINS-1:0] digital_oe,
   output wire [PINS-1:0] pull_up_enable,
   output wire irq
);
   localparam ST_IDLE = 3'b001;
   localparam ST_ARMED = 3'b010;
   localparam ST_CONV = 3'b100;
   reg [7:0] ctl0_q;
   reg [7:0] ctl1_q;
   reg [7:0] psel0_q;
   reg [7:0] psel1_q;
   reg [11:0] result_q;
   reg [2:0] state_q;
   reg [4:0] bit_cnt_q;
   reg busy_q;
   reg irq_status_q;
   reg irq_mask_q;
   reg aw_held_q;
   reg w_held_q;
   reg [4:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   wire tick;
   wire do_write;
   wire done;
   wire start_bit;
   wire power_down;
   reg [7:0] res_low;
   reg [7:0] res_high;
   reg [31:0] rd_val;
   reg rd_ok;
   conv_clock_gen #(.SUB_DIV(SUB_DIV)) u_clk (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_sel(ctl1_q[2:0]),
      .tick(tick)
   );
   pin_function_mux #(.PINS(PINS)) u_pins (
      .analog_sel(psel0_q[PINS-1:0]),
      .pull_up_cfg(pull_up_cfg),
      .digital_oe_req(digital_oe_req),
      .analog_connect(analog_connect),
      .digital_enable(digital_enable),
      .digital_oe(digital_oe),
      .pull_up_enable(pull_up_enable)
   );
   assign start_bit = ctl0_q[`CTL0_START];
   assign power_down = ctl0_q[`CTL0_POWER_DOWN];
   // Address and data are latched independently so either may arrive first
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 5'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Conversion sequencer; a start that rises arms, its fall launches
   assign done = (state_q == ST_CONV) && tick && (bit_cnt_q == `CONV_CLOCKS - 5'h01);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 5'h00;
         busy_q <= 1'b1;
         result_q <= 12'h000;
      end
      else if (power_down)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 5'h00;
         // A start pulse while powered down still reports busy, as no result will follow
         if (start_bit)
            busy_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (start_bit)
               begin
                  state_q <= ST_ARMED;
                  busy_q <= 1'b1;
               end
            end
            ST_ARMED:
            begin
               busy_q <= 1'b1;
               if (!start_bit)
               begin
                  state_q <= ST_CONV;
                  bit_cnt_q <= 5'h00;
               end
            end
            ST_CONV:
            begin
               if (start_bit)
               begin
                  state_q <= ST_ARMED;
                  busy_q <= 1'b1;
               end
               else if (done)
               begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  result_q <= core_result;
               end
               else if (tick)
                  bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
   // Channel decode drives one source index only
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         source_select <= 4'h0;
         core_reset <= 1'b1;
         core_power_on <= 1'b0;
         core_sample <= 1'b0;
         reference_select <= 2'h0;
         reference_pin_claim <= 1'b0;
         bandgap_on <= 1'b0;
      end
      else
      begin
         if (ctl0_q[4])
            source_select <= `SRC_BANDGAP;
         else if (ctl0_q[3])
            source_select <= (ctl0_q[2:0] == 3'h0) ? `SRC_DEMOD : `SRC_OVERCURRENT;
         else
            source_select <= {1'b0, ctl0_q[2:0]};
         core_reset <= start_bit | power_down;
         core_power_on <= ~power_down;
         core_sample <= (state_q == ST_CONV) & tick & ~start_bit & ~power_down;
         reference_select <= ctl1_q[4:3];
         reference_pin_claim <= (ctl1_q[4:3] == `REF_EXTERNAL);
         bandgap_on <= ctl1_q[`CTL1_BANDGAP];
      end
   end
   // Register writes; busy and results are never written by software
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl0_q <= `CTL0_RESET;
         ctl1_q <= `CTL1_RESET;
         psel0_q <= 8'h00;
         psel1_q <= 8'h00;
         irq_status_q <= 1'b0;
         irq_mask_q <= 1'b0;
      end
      else
      begin
         ctl0_q[`CTL0_BUSY] <= busy_q;
         if (do_write && wstrb_q[0])
         begin
            case (awaddr_q)
               {1'b0, `OFS_CONTROL_0}:
               begin
                  ctl0_q[7] <= wdata_q[7];
                  ctl0_q[5:0] <= wdata_q[5:0];
               end
               {1'b0, `OFS_CONTROL_1}: ctl1_q <= {1'b0, wdata_q[6:0]};
               `OFS_PORT_SEL_0: psel0_q <= wdata_q[7:0];
               `OFS_PORT_SEL_1: psel1_q <= wdata_q[7:0];
               `OFS_IRQ_MASK: irq_mask_q <= wdata_q[0];
               default: ;
            endcase
         end
         // Set wins over a write-one clear in the same cycle
         if (done)
            irq_status_q <= 1'b1;
         else if (do_write && wstrb_q[0] && awaddr_q == `OFS_IRQ_STATUS && wdata_q[0])
            irq_status_q <= 1'b0;
      end
   end
   assign irq = irq_status_q & irq_mask_q;
   always @*
   begin
      if (ctl1_q[`CTL1_ALIGN])
      begin
         res_high = {4'h0, result_q[11:8]};
         res_low = result_q[7:0];
      end
      else
      begin
         res_high = result_q[11:4];
         res_low = {result_q[3:0], 4'h0};
      end
   end
   always @*
   begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         {1'b0, `OFS_RESULT_LOW}: rd_val = {24'h000000, res_low};
         {1'b0, `OFS_RESULT_HIGH}: rd_val = {24'h000000, res_high};
         {1'b0, `OFS_CONTROL_0}: rd_val = {24'h000000, ctl0_q[7], busy_q, ctl0_q[5:0]};
         {1'b0, `OFS_CONTROL_1}: rd_val = {24'h000000, ctl1_q};
         `OFS_PORT_SEL_0: rd_val = {24'h000000, psel0_q};
         `OFS_PORT_SEL_1: rd_val = {24'h000000, psel1_q};
         `OFS_IRQ_STATUS: rd_val = {31'h00000000, irq_status_q};
         `OFS_IRQ_MASK: rd_val = {31'h00000000, irq_mask_q};
         default:
         begin
            rd_val = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// file: test/core_model.sv
/*
 Stand-in for the analog core: answers with a value tied to the selected source.
 Assumes the control block captures core_result when a conversion ends.
*/
`timescale 1ns/1ps
module core_model (
   input logic aclk,
   input logic core_reset,
   input logic [3:0] source_select,
   output logic [11:0] core_result
);
   initial core_result = 12'h000;
   // Changing junk while held in reset, so a capture at the wrong moment shows
   always @(posedge aclk)
   begin
      if (core_reset)
         core_result <= ~core_result;
      else
         core_result <= {source_select, 8'ha5};
   end
endmodule

// file: test/adc_ctrl_asserts.sv
/*
 Checker for the converter control block: pin steering, reference and power relations.
 Assumes it is bound to adc_conversion_control and sees only its ports.
*/
`timescale 1ns/1ps
module adc_ctrl_asserts #(
   parameter PINS = 8
)(
   input logic aclk,
   input logic aresetn,
   input logic core_reset,
   input logic core_power_on,
   input logic core_sample,
   input logic [3:0] source_select,
   input logic [1:0] reference_select,
   input logic reference_pin_claim,
   input logic [PINS-1:0] pull_up_cfg,
   input logic [PINS-1:0] digital_oe_req,
   input logic [PINS-1:0] analog_connect,
   input logic [PINS-1:0] digital_enable,
   input logic [PINS-1:0] digital_oe,
   input logic [PINS-1:0] pull_up_enable
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_ref_claim: assert property (reference_pin_claim == (reference_select == 2'h1))
      else $error("pin claim differs from reference code");
   chk_source_range: assert property (source_select <= 4'ha)
      else $error("source code out of range");
   chk_pull_cut: assert property (pull_up_enable == (pull_up_cfg & ~analog_connect))
      else $error("pull-up wrong for pin function");
   chk_oe_cut: assert property (digital_oe == (digital_oe_req & ~analog_connect))
      else $error("output enable wrong for pin function");
   chk_digital_off: assert property ((digital_enable & analog_connect) == '0)
      else $error("analog pin keeps digital path");
   chk_power_reset: assert property (!core_power_on |-> core_reset)
      else $error("core not reset while powered down");
   chk_power_quiet: assert property (!core_power_on |-> !core_sample)
      else $error("sampling while powered down");
   chk_reset_quiet: assert property (core_reset [*2] |-> !core_sample)
      else $error("sampling while core held in reset");
   cov_sample: cover property (core_sample);
   cov_claim: cover property (reference_pin_claim);
   cov_analog: cover property (analog_connect != '0);
endmodule
bind adc_conversion_control adc_ctrl_asserts #(.PINS(PINS)) adc_ctrl_asserts_inst (
   .aclk(aclk),
   .aresetn(aresetn),
   .core_reset(core_reset),
   .core_power_on(core_power_on),
   .core_sample(core_sample),
   .source_select(source_select),
   .reference_select(reference_select),
   .reference_pin_claim(reference_pin_claim),
   .pull_up_cfg(pull_up_cfg),
   .digital_oe_req(digital_oe_req),
   .analog_connect(analog_connect),
   .digital_enable(digital_enable),
   .digital_oe(digital_oe),
   .pull_up_enable(pull_up_enable)
);

// file: test/test_adc_conversion_control.sv
/*
 Self-checking bench for the converter control block over AXI4-Lite.
 Assumes the core model beside it and a shortened subsystem clock divider.
*/
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module test_adc_conversion_control;
   localparam int SUBD = 5;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [7:0] pull_up_cfg = 8'hff, digital_oe_req = 8'h3c;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, reference_select, r;
   logic [31:0] s_axi_rdata, d;
   logic [11:0] core_result;
   logic core_reset, core_power_on, core_sample, reference_pin_claim, bandgap_on, irq;
   logic [3:0] source_select;
   logic [7:0] analog_connect, digital_enable, digital_oe, pull_up_enable;
   int num_errors = 0, cmp_count = 0;
   adc_conversion_control #(.SUB_DIV(12'(SUBD)), .PINS(8)) adc_conversion_control_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .core_result(core_result),
      .core_reset(core_reset),
      .core_power_on(core_power_on),
      .core_sample(core_sample),
      .source_select(source_select),
      .reference_select(reference_select),
      .reference_pin_claim(reference_pin_claim),
      .bandgap_on(bandgap_on),
      .pull_up_cfg(pull_up_cfg),
      .digital_oe_req(digital_oe_req),
      .analog_connect(analog_connect),
      .digital_enable(digital_enable),
      .digital_oe(digital_oe),
      .pull_up_enable(pull_up_enable),
      .irq(irq)
   );
   core_model core_model_inst (
      .aclk(aclk),
      .core_reset(core_reset),
      .source_select(source_select),
      .core_result(core_result)
   );
   always #5 aclk = ~aclk;
   task test_done;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // bready and rready stay high, so each wait ends at the answer edge
   task wr(input logic [4:0] a, input logic [7:0] v);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      r = s_axi_bresp;
      // One more edge so outputs registered from the new register value have settled
      @(posedge aclk);
      if (n >= 50)
         num_errors++;
   endtask
   task rd(input logic [4:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 50)
         num_errors++;
   endtask
   task wait_sample(output int n);
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end while (core_sample !== 1'b1 && n < 2000);
   endtask
   function automatic logic [3:0] exp_src(input logic [4:0] c);
      if (c[4])
         return 4'ha;
      if (c[3])
         return (c[2:0] == 3'h0) ? 4'h8 : 4'h9;
      return {1'b0, c[2:0]};
   endfunction
   task reset_vals;
      rd(`OFS_CONTROL_0);
      cmp(d, 32'h60);
      rd(`OFS_CONTROL_1);
      cmp(d, 32'h0);
      rd(5'h02);
      cmp(r, 2'h2);
      cmp(d, 32'h0);
      wr(5'h01, 8'h00);
      cmp(r, 2'h2);
   endtask
   task pins_ref;
      wr(`OFS_PORT_SEL_0, 8'h0f);
      cmp(analog_connect, 8'h0f);
      cmp({digital_enable, digital_oe}, {8'hf0, 8'h30});
      cmp(pull_up_enable, 8'hf0);
      wr(`OFS_PORT_SEL_1, 8'h5a);
      cmp(r, 2'h0);
      rd(`OFS_PORT_SEL_1);
      cmp(d, 32'h5a);
      wr(`OFS_CONTROL_1, 8'h48);
      cmp({reference_select, reference_pin_claim, bandgap_on}, {2'h1, 2'h3});
      wr(`OFS_CONTROL_1, 8'h10);
      cmp({reference_select, reference_pin_claim, bandgap_on}, {2'h2, 2'h0});
   endtask
   task chan_map;
      logic [4:0] codes [7];
      codes = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0f, 5'h10, 5'h1f};
      foreach (codes[i])
      begin
         wr(`OFS_CONTROL_0, {3'h1, codes[i]});
         cmp(source_select, exp_src(codes[i]));
      end
   endtask
   task conv(input logic [4:0] ch, input logic [2:0] sel, input int per);
      logic [11:0] v;
      int n;
      v = {exp_src(ch), 8'ha5};
      wr(`OFS_CONTROL_1, {5'h0, sel});
      wr(`OFS_CONTROL_0, {3'h4, ch});
      rd(`OFS_CONTROL_0);
      cmp(core_reset, 1'b1);
      cmp(d, {24'h0, 3'h6, ch});
      wr(`OFS_CONTROL_0, {3'h0, ch});
      wait_sample(n);
      wait_sample(n);
      cmp(n, per);
      n = 0;
      do
      begin
         rd(`OFS_CONTROL_0);
         n++;
      end while (d[6] !== 1'b0 && n < 200);
      cmp({d[6], irq}, 2'h1);
      wr(`OFS_IRQ_MASK, 8'h00);
      cmp(irq, 1'b0);
      wr(`OFS_IRQ_MASK, 8'h01);
      rd(`OFS_RESULT_HIGH);
      cmp(d, {24'h0, v[11:4]});
      rd(`OFS_RESULT_LOW);
      cmp(d, {24'h0, v[3:0], 4'h0});
      wr(`OFS_CONTROL_1, {5'h4, sel});
      rd(`OFS_RESULT_HIGH);
      cmp(d, {28'h0, v[11:8]});
      wr(`OFS_RESULT_LOW, 8'h00);
      rd(`OFS_RESULT_LOW);
      cmp(d, {24'h0, v[7:0]});
      wr(`OFS_IRQ_STATUS, 8'h01);
      cmp(irq, 1'b0);
   endtask
   task pdown;
      wr(`OFS_CONTROL_0, 8'ha3);
      wr(`OFS_CONTROL_0, 8'h23);
      repeat (40) @(posedge aclk);
      cmp({core_power_on, core_reset, irq}, 3'h2);
      rd(`OFS_CONTROL_0);
      cmp(d, 32'h63);
   endtask
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      reset_vals();
      wr(`OFS_IRQ_MASK, 8'h01);
      pins_ref();
      chan_map();
      conv(5'h03, 3'h3, 8);
      conv(5'h08, 3'h7, SUBD);
      conv(5'h1f, 3'h0, 1);
      pdown();
      test_done();
   end
   initial
   begin
      #300000;
      num_errors++;
      test_done();
   end
endmodule
